// ===== hw/irq_control_regs.sv
// Purpose: interrupt sequencing and core control registers
// Assumes: clk_sys is the instruction-cycle clock; core stalls on seqBusy
// Notes: memory reads answer one cycle after the request
//
// Overview of operation
// - acknowledge pushes PC, SP minus two, vectors
// - every return pops PC, then SP plus two
// - interrupt return also sets the global enable
// - software interrupt leaves the global enable alone
// - enable re-arms nesting; only software clears pending
// - acknowledge may start while an enable clears
// - missing program bytes read zero, opcode zero traps
// - missing data bytes read all ones
// - stack grows down; unbalanced return pops ones
// - timer mode bits on top, then run bit
// - serial select routes two port pins
// - low two bits pick serial divisor 2/4/8
// - status word bit layout, half-carry down to enable
// - timer pending on underflow or capture
// - status word shows serial shifter busy
// - carry changes always update half-carry too
// - second control register layout with read-only bits
// - edge select zero rising, one falling
// - per-source enables gate sources under global enable
`timescale 1ns/100ps
`include "irq_ctrl_regs.svh"
module irq_control_regs (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	// data memory port
	input  wire irq_ctrl_pkg::mem_req_t memReq,
	input  wire logic [7:0]           otherRdData,
	input  wire logic                 otherRdHit,
	output logic [7:0]                memRdData,
	// program fetch
	input  wire logic                 fetchEn,
	input  wire logic [7:0]           romRdData,
	input  wire logic                 romRdHit,
	output logic [7:0]                fetchData,
	// core sequencing
	input  wire logic                 instrBoundary,
	input  wire irq_ctrl_pkg::return_kind_t retKind,
	input  wire logic [14:0]          pcNow,
	output logic                      seqBusy,
	output logic                      pcLoad,
	output logic [14:0]               pcLoadValue,
	output logic                      skipNext,
	// alu flags
	input  wire logic                 aluFlagWe,
	input  wire logic                 aluCarry,
	input  wire logic                 aluHalfCarry,
	// stack access
	output irq_ctrl_pkg::mem_req_t    stackReq,
	input  wire logic [7:0]           stackRdData,
	input  wire logic                 stackRdHit,
	// events and status
	input  wire logic                 extIrqPin,
	input  wire logic                 timerUnderflow,
	input  wire logic                 timerCapture,
	input  wire logic                 serialBusy,
	input  wire logic                 watchdogUnderflow,
	input  wire logic                 comparatorPin,
	// configuration
	output logic [2:0]                timerMode,
	output logic                      timerRun,
	output logic                      portPinFiveIsClock,
	output logic                      portPinFourIsData,
	output logic [3:0]                serialClkDiv,
	output logic [2:0]                modulatorMode,
	output logic                      comparatorEnable,
	output logic                      comparatorPinOut
);
	import irq_ctrl_pkg::*;
	default clocking chkClk @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	seq_state_t         state;
	seq_state_t         next_state;
	status_word_t       processor_status_word;
	status_word_t       next_psw;
	timer_serial_ctrl_t tsc;
	timer_serial_ctrl_t next_tsc;
	mod_cmp_ctrl_t      mcc;
	mod_cmp_ctrl_t      next_mcc;
	logic [7:0]         sp;
	logic [7:0]         next_sp;
	logic [14:0]        savedPc;
	logic [14:0]        next_savedPc;
	logic [2:0]         holdCnt;
	logic [2:0]         next_holdCnt;
	logic [6:0]         popHi;
	logic [6:0]         next_popHi;
	return_kind_t       retLatched;
	return_kind_t       next_retLatched;
	logic               clearGie;
	logic               softAck;
	logic               irqRequest;
	logic               softTrap;
	logic               next_seqBusy;
	logic               next_pcLoad;
	logic [14:0]        next_pcLoadValue;
	logic               next_skipNext;
	mem_req_t           next_stackReq;
	logic [7:0]         stackByte;
	logic [7:0]         next_memRdData;
	logic [7:0]         next_fetchData;
	logic [3:0]         next_serialClkDiv;
	logic               next_comparatorPinOut;
	logic               cmpSync1;
	logic               cmpSync2;
	logic               extPendingFlag;
	logic               timerPendingFlag;
	logic               statusWrite;

	assign statusWrite = memReq.wrEn && memReq.addr == `ADDR_STATUS_WORD;

	irq_source_flags u_flags (
		.clk_sys        (clk_sys),
		.resetn         (resetn),
		.extIrqPin      (extIrqPin),
		.extEdgeSelect  (tsc.extEdgeSelect),
		.timerUnderflow (timerUnderflow),
		.timerCapture   (timerCapture),
		.swWrite        (statusWrite),
		.swExtPending   (memReq.wrData[`BIT_EXT_PENDING]),
		.swTimerPending (memReq.wrData[`BIT_TIMER_PENDING]),
		.extIrqPending  (extPendingFlag),
		.timerIrqPending(timerPendingFlag)
	);

	// sequencer
	always_comb begin
		// decision uses current enables, so a clearing write still loses
		irqRequest = processor_status_word.globalIrqEnable &
		             ((processor_status_word.extIrqEnable & processor_status_word.extIrqPending) |
		              (processor_status_word.timerIrqEnable & processor_status_word.timerIrqPending));
		softTrap = fetchData == `OPCODE_SOFT_IRQ;
		// absent stack bytes read as ones, so a stray pop jumps to 7fff
		stackByte = stackRdHit ? stackRdData : `UNMAPPED_READ;
		next_state = state;
		next_holdCnt = holdCnt;
		next_savedPc = savedPc;
		next_popHi = popHi;
		next_retLatched = retLatched;
		clearGie = 1'b0;
		softAck = 1'b0;
		next_pcLoad = 1'b0;
		next_pcLoadValue = pcLoadValue;
		next_skipNext = 1'b0;
		case (state)
			S_IDLE: begin
				if (instrBoundary) begin
					if (softTrap) begin
						softAck = 1'b1;
						next_savedPc = pcNow;
						next_state = S_PUSHL;
					end else if (irqRequest) begin
						clearGie = 1'b1;
						next_savedPc = pcNow;
						next_state = S_PUSHL;
					end else if (|retKind) begin
						next_retLatched = retKind;
						next_state = S_POPH;
					end
				end
			end
			S_PUSHL: next_state = S_PUSHH;
			S_PUSHH: begin
				next_state = S_VECT;
				next_pcLoad = 1'b1;
				next_pcLoadValue = `IRQ_VECTOR;
			end
			S_VECT: begin
				next_state = S_HOLD;
				next_holdCnt = `ACK_HOLD_CYCLES;
			end
			S_HOLD: begin
				next_holdCnt = holdCnt - 3'h1;
				if (holdCnt == 3'h1)
					next_state = S_IDLE;
			end
			S_POPH: begin
				next_popHi = stackByte[6:0];
				next_state = S_POPL;
			end
			S_POPL: begin
				next_pcLoad = 1'b1;
				next_pcLoadValue = {popHi, stackByte};
				next_skipNext = retLatched.returnSkipInstr;
				next_state = S_RETLD;
			end
			S_RETLD: next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
		next_seqBusy = next_state != S_IDLE;
	end

	// registers, stack pointer and read mux
	always_comb begin
		next_psw = processor_status_word;
		next_tsc = tsc;
		next_mcc = mcc;
		next_sp = sp;
		if (memReq.wrEn) begin
			case (memReq.addr)
				`ADDR_TIMER_SERIAL_CTRL: next_tsc = memReq.wrData;
				`ADDR_STATUS_WORD:       next_psw = memReq.wrData;
				`ADDR_MOD_CMP_CTRL:
					next_mcc = (memReq.wrData & `MASK_MOD_CMP_WRITABLE) |
					           (mcc & ~`MASK_MOD_CMP_WRITABLE);
				`ADDR_STACK_PTR:         next_sp = memReq.wrData;
				default: next_sp = sp;
			endcase
		end
		if (aluFlagWe) begin
			next_psw.carry = aluCarry;
			next_psw.halfCarryFlag = aluHalfCarry;
		end
		// pending flags are owned by the flag block, never cleared here
		next_psw.extIrqPending = extPendingFlag;
		next_psw.timerIrqPending = timerPendingFlag;
		next_psw.serialBusy = serialBusy;
		next_mcc.comparatorResult = cmpSync2;
		next_mcc.watchdogUnderflowFlag = watchdogUnderflow;
		next_mcc.unused0 = 1'b0;
		if (clearGie)
			next_psw.globalIrqEnable = 1'b0;
		if (state == S_RETLD && retLatched.returnIrqInstr)
			next_psw.globalIrqEnable = 1'b1;
		if (state == S_PUSHL || state == S_PUSHH)
			next_sp = sp - `STACK_STEP;
		if (state == S_RETLD)
			next_sp = sp + `STACK_STEP + `STACK_STEP;
		next_stackReq = '0;
		if (next_state == S_PUSHL || next_state == S_PUSHH) begin
			next_stackReq.wrEn = 1'b1;
			next_stackReq.addr = next_sp;
			next_stackReq.wrData = (next_state == S_PUSHL) ?
			    next_savedPc[7:0] : {1'b0, next_savedPc[14:8]};
		end else if (next_state == S_POPH || next_state == S_POPL) begin
			next_stackReq.rdEn = 1'b1;
			next_stackReq.addr = next_sp +
			    ((next_state == S_POPH) ? `STACK_STEP : 8'h02);
		end
		case (memReq.addr)
			`ADDR_TIMER_SERIAL_CTRL: next_memRdData = tsc;
			`ADDR_STATUS_WORD:       next_memRdData = processor_status_word;
			`ADDR_MOD_CMP_CTRL:      next_memRdData = mcc;
			`ADDR_STACK_PTR:         next_memRdData = sp;
			default: next_memRdData = otherRdHit ? otherRdData
			                                     : `UNMAPPED_READ;
		endcase
		if (!memReq.rdEn)
			next_memRdData = memRdData;
		next_fetchData = fetchData;
		if (fetchEn)
			next_fetchData = romRdHit ? romRdData : `UNMAPPED_FETCH;
		case ({next_tsc.serialDivHi, next_tsc.serialDivLo})
			2'b00:   next_serialClkDiv = `SERIAL_DIV_2;
			2'b01:   next_serialClkDiv = `SERIAL_DIV_4;
			default: next_serialClkDiv = `SERIAL_DIV_8;
		endcase
		// pin stays low unless both enables are set
		next_comparatorPinOut = next_mcc.comparatorEnable &
		    next_mcc.comparatorOutEnable & cmpSync2;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state <= S_IDLE;
			holdCnt <= 3'h0;
			savedPc <= 15'h0000;
			popHi <= 7'h00;
			retLatched <= '0;
			processor_status_word <= `RESET_STATUS_WORD;
			tsc <= `RESET_TIMER_SERIAL_CTRL;
			mcc <= `RESET_MOD_CMP_CTRL;
			sp <= `RESET_STACK_PTR;
			seqBusy <= 1'b0;
			pcLoad <= 1'b0;
			pcLoadValue <= 15'h0000;
			skipNext <= 1'b0;
			stackReq <= '0;
			memRdData <= 8'h00;
			fetchData <= 8'h01;
			serialClkDiv <= `SERIAL_DIV_2;
			comparatorPinOut <= 1'b0;
			cmpSync1 <= 1'b0;
			cmpSync2 <= 1'b0;
		end else begin
			state <= next_state;
			holdCnt <= next_holdCnt;
			savedPc <= next_savedPc;
			popHi <= next_popHi;
			retLatched <= next_retLatched;
			processor_status_word <= next_psw;
			tsc <= next_tsc;
			mcc <= next_mcc;
			sp <= next_sp;
			seqBusy <= next_seqBusy;
			pcLoad <= next_pcLoad;
			pcLoadValue <= next_pcLoadValue;
			skipNext <= next_skipNext;
			stackReq <= next_stackReq;
			memRdData <= next_memRdData;
			fetchData <= next_fetchData;
			serialClkDiv <= next_serialClkDiv;
			comparatorPinOut <= next_comparatorPinOut;
			cmpSync1 <= comparatorPin;
			cmpSync2 <= cmpSync1;
		end
	end

	assign timerMode = tsc.timerMode;
	assign timerRun = tsc.timerRun;
	assign portPinFiveIsClock = tsc.serialPinSelect;
	assign portPinFourIsData = tsc.serialPinSelect;
	assign modulatorMode = mcc.modulatorMode;
	assign comparatorEnable = mcc.comparatorEnable;

	chk_ack_clears_gie: assert property (
		(state == S_IDLE && instrBoundary && !softTrap && irqRequest)
		|=> !processor_status_word.globalIrqEnable)
		else $error("acknowledge left global enable set");
	chk_ack_vector: assert property (
		(state == S_PUSHL) |-> ##2 (pcLoad && pcLoadValue == `IRQ_VECTOR))
		else $error("vector not loaded");
	chk_ack_length: assert property (
		(state == S_PUSHL) |-> seqBusy [*6] ##1 !seqBusy)
		else $error("acknowledge not seven cycles");
	chk_push_sp: assert property (
		(state == S_PUSHL) |-> ##2 (sp == $past(sp, 2) - 8'h02))
		else $error("stack pointer not down by two");
	chk_return_sp: assert property (
		(state == S_RETLD) |=> (sp == $past(sp) + 8'h02))
		else $error("stack pointer not up by two");
	chk_return_irq_instr_gie: assert property (
		(state == S_RETLD && retLatched.returnIrqInstr)
		|=> processor_status_word.globalIrqEnable)
		else $error("interrupt return left enable clear");
	chk_soft_keep_gie: assert property (
		(state == S_IDLE && instrBoundary && softTrap && !memReq.wrEn)
		|=> $stable(processor_status_word.globalIrqEnable))
		else $error("software trap changed global enable");
	chk_pending_kept: assert property (
		(extPendingFlag && !statusWrite) |=> extPendingFlag)
		else $error("pending flag cleared by hardware");
	chk_fetch_zero: assert property (
		(fetchEn && !romRdHit) |=> (fetchData == 8'h00))
		else $error("missing program byte not zero");
	chk_unmapped_ones: assert property (
		(memReq.rdEn && !otherRdHit && memReq.addr < 8'hc0)
		|=> (memRdData == 8'hff))
		else $error("missing data byte not all ones");
	chk_pop_ones: assert property (
		(state == S_POPL && !stackRdHit) |=> (pcLoadValue[7:0] == 8'hff))
		else $error("missing stack byte not all ones");

endmodule // irq_control_regs

// ===== hw/irq_source_flags.sv
// Purpose: external edge detect and the two sticky pending flags
// Assumes: external pin is asynchronous, timer events are clk_sys pulses
// Notes: software clears the flags; a same-cycle event wins
`timescale 1ns/100ps
module irq_source_flags (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// sources
	input  wire logic extIrqPin,
	input  wire logic extEdgeSelect,
	input  wire logic timerUnderflow,
	input  wire logic timerCapture,
	// software write of the status word
	input  wire logic swWrite,
	input  wire logic swExtPending,
	input  wire logic swTimerPending,
	// flags
	output logic      extIrqPending,
	output logic      timerIrqPending
);
	import irq_ctrl_pkg::*;

	logic extSync1;
	logic extSync2;
	logic extPrev;
	logic extEdge;
	logic next_extIrqPending;
	logic next_timerIrqPending;

	always_comb begin
		// edge select low picks rising, high picks falling
		extEdge = extEdgeSelect ? (extPrev & ~extSync2)
		                        : (~extPrev & extSync2);
		next_extIrqPending = extIrqPending;
		next_timerIrqPending = timerIrqPending;
		if (swWrite) begin
			next_extIrqPending = swExtPending;
			next_timerIrqPending = swTimerPending;
		end
		// set wins over a clear in the same cycle
		if (extEdge)
			next_extIrqPending = 1'b1;
		if (timerUnderflow | timerCapture)
			next_timerIrqPending = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			extSync1 <= 1'b0;
			extSync2 <= 1'b0;
			extPrev <= 1'b0;
			extIrqPending <= 1'b0;
			timerIrqPending <= 1'b0;
		end else begin
			extSync1 <= extIrqPin;
			extSync2 <= extSync1;
			extPrev <= extSync2;
			extIrqPending <= next_extIrqPending;
			timerIrqPending <= next_timerIrqPending;
		end
	end

endmodule // irq_source_flags

// ===== shared/irq_ctrl_pkg.sv
// Purpose: types shared by the interrupt and control register block
// Assumes: field order follows the register bit order, bit 7 first
// Notes: none
package irq_ctrl_pkg;

	typedef enum logic [7:0] {
		S_IDLE  = 8'h01,
		S_PUSHL = 8'h02,
		S_PUSHH = 8'h04,
		S_VECT  = 8'h08,
		S_HOLD  = 8'h10,
		S_POPH  = 8'h20,
		S_POPL  = 8'h40,
		S_RETLD = 8'h80
	} seq_state_t;

	typedef struct packed {
		logic halfCarryFlag;
		logic carry;
		logic timerIrqPending;
		logic timerIrqEnable;
		logic extIrqPending;
		logic serialBusy;
		logic extIrqEnable;
		logic globalIrqEnable;
	} status_word_t;

	typedef struct packed {
		logic [2:0] timerMode;
		logic       timerRun;
		logic       serialPinSelect;
		logic       extEdgeSelect;
		logic       serialDivHi;
		logic       serialDivLo;
	} timer_serial_ctrl_t;

	typedef struct packed {
		logic [2:0] modulatorMode;
		logic       comparatorEnable;
		logic       comparatorResult;
		logic       comparatorOutEnable;
		logic       watchdogUnderflowFlag;
		logic       unused0;
	} mod_cmp_ctrl_t;

	typedef struct packed {
		logic returnInstr;
		logic returnSkipInstr;
		logic returnIrqInstr;
	} return_kind_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic       wrEn;
		logic       rdEn;
	} mem_req_t;

endpackage

// ===== shared/irq_ctrl_regs.svh
// Purpose: addresses, field positions, reset values and counts
// Assumes: 8-bit data memory space, 15-bit program counter
// Notes: included by bare name
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

`define ADDR_MOD_CMP_CTRL      8'hcc
`define ADDR_TIMER_SERIAL_CTRL 8'hee
`define ADDR_STATUS_WORD       8'hef
`define ADDR_STACK_PTR         8'hfd

`define RESET_MOD_CMP_CTRL      8'h00
`define RESET_TIMER_SERIAL_CTRL 8'h00
`define RESET_STATUS_WORD       8'h00
`define RESET_STACK_PTR         8'h6f

`define BIT_TIMER_PENDING 5
`define BIT_EXT_PENDING   3
`define MASK_MOD_CMP_WRITABLE 8'hf4

`define IRQ_VECTOR       15'h00ff
`define ACK_CYCLES       7
`define ACK_HOLD_CYCLES  3'h3
`define UNMAPPED_READ    8'hff
`define UNMAPPED_FETCH   8'h00
`define OPCODE_SOFT_IRQ  8'h00
`define STACK_STEP       8'h01

`define SERIAL_DIV_2 4'h2
`define SERIAL_DIV_4 4'h4
`define SERIAL_DIV_8 4'h8

`endif

// ===== verification/interrupt_and_control_regs_bench.sv
// Purpose: self-checking bench for the interrupt and control registers
// Assumes: stack RAM and event sources come from irq_far_side
// Notes: one task per scenario, fixed latencies from the hand-over
`timescale 1ns/100ps
`include "irq_ctrl_regs.svh"
module interrupt_and_control_regs_bench;
	import irq_ctrl_pkg::*;
	logic clk_sys, resetn, otherRdHit, fetchEn, romRdHit, instrBoundary;
	logic seqBusy, pcLoad, skipNext, aluFlagWe, aluCarry, aluHalfCarry;
	logic stackRdHit, extIrqPin, timerUnderflow, timerCapture, serialBusy;
	logic watchdogUnderflow, comparatorPin, timerRun, comparatorEnable;
	logic portPinFiveIsClock, portPinFourIsData, comparatorPinOut, skipSeen;
	logic [7:0] otherRdData, memRdData, romRdData, fetchData, stackRdData;
	logic [14:0] pcNow, pcLoadValue, loadVal;
	logic [2:0] timerMode, modulatorMode;
	logic [3:0] serialClkDiv;
	mem_req_t memReq, stackReq, req1, req2;
	return_kind_t retKind;
	int n_fail, tests_run, busyCnt, loadAt;
	irq_control_regs dut (
		.clk_sys(clk_sys), .resetn(resetn), .memReq(memReq),
		.otherRdData(otherRdData), .otherRdHit(otherRdHit),
		.memRdData(memRdData), .fetchEn(fetchEn), .romRdData(romRdData),
		.romRdHit(romRdHit), .fetchData(fetchData),
		.instrBoundary(instrBoundary), .retKind(retKind), .pcNow(pcNow),
		.seqBusy(seqBusy), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
		.skipNext(skipNext), .aluFlagWe(aluFlagWe), .aluCarry(aluCarry),
		.aluHalfCarry(aluHalfCarry), .stackReq(stackReq),
		.stackRdData(stackRdData), .stackRdHit(stackRdHit),
		.extIrqPin(extIrqPin), .timerUnderflow(timerUnderflow),
		.timerCapture(timerCapture), .serialBusy(serialBusy),
		.watchdogUnderflow(watchdogUnderflow),
		.comparatorPin(comparatorPin), .timerMode(timerMode),
		.timerRun(timerRun), .portPinFiveIsClock(portPinFiveIsClock),
		.portPinFourIsData(portPinFourIsData),
		.serialClkDiv(serialClkDiv), .modulatorMode(modulatorMode),
		.comparatorEnable(comparatorEnable),
		.comparatorPinOut(comparatorPinOut)
	);
	irq_far_side far (
		.clk_sys(clk_sys), .stackReq(stackReq), .stackRdData(stackRdData),
		.stackRdHit(stackRdHit), .extIrqPin(extIrqPin),
		.timerUnderflow(timerUnderflow), .timerCapture(timerCapture)
	);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		memReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
		@(posedge clk_sys);
		memReq <= '0;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		memReq <= '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
		@(posedge clk_sys);
		memReq <= '0;
		// data stands from the read edge on; sampling one edge later
		@(posedge clk_sys);
		check(memRdData, exp);
	endtask
	task automatic fetch(input logic hit, input logic [7:0] d);
		@(posedge clk_sys);
		fetchEn <= 1'b1;
		romRdHit <= hit;
		romRdData <= d;
		@(posedge clk_sys);
		fetchEn <= 1'b0;
	endtask
	task automatic alu(input logic c, input logic h);
		@(posedge clk_sys);
		aluFlagWe <= 1'b1;
		aluCarry <= c;
		aluHalfCarry <= h;
		@(posedge clk_sys);
		aluFlagWe <= 1'b0;
	endtask
	// boundary pulse, then eight cycles of sequencer outputs recorded
	task automatic bnd(input return_kind_t k, input logic [14:0] pc);
		@(posedge clk_sys);
		instrBoundary <= 1'b1;
		retKind <= k;
		pcNow <= pc;
		@(posedge clk_sys);
		instrBoundary <= 1'b0;
		retKind <= '0;
		busyCnt = 0;
		loadAt = 0;
		skipSeen = 1'b0;
		for (int i = 1; i <= 8; i++) begin
			@(negedge clk_sys);
			if (seqBusy === 1'b1) busyCnt++;
			if (i == 1) req1 = stackReq;
			if (i == 2) req2 = stackReq;
			if (pcLoad === 1'b1) begin
				loadAt = i;
				loadVal = pcLoadValue;
				skipSeen = skipNext;
			end
		end
	endtask
	task automatic t_reset();
		rdChk(`ADDR_MOD_CMP_CTRL, 8'h00);
		rdChk(`ADDR_TIMER_SERIAL_CTRL, 8'h00);
		rdChk(`ADDR_STATUS_WORD, 8'h00);
		rdChk(`ADDR_STACK_PTR, 8'h6f);
		rdChk(8'h75, 8'hff);
		otherRdHit <= 1'b1;
		otherRdData <= 8'h3c;
		rdChk(8'hd4, 8'h3c);
		otherRdHit <= 1'b0;
		$display("reset and unmapped reads done");
	endtask
	task automatic t_timer_ctrl();
		logic [3:0] div;
		for (int s = 0; s < 4; s++) begin
			wr(`ADDR_TIMER_SERIAL_CTRL, {6'b101110, s[1:0]});
			div = s[1] ? `SERIAL_DIV_8 : (s[0] ? `SERIAL_DIV_4 : `SERIAL_DIV_2);
			rdChk(`ADDR_TIMER_SERIAL_CTRL, {6'b101110, s[1:0]});
			check({timerMode, timerRun}, 4'hb);
			check({portPinFiveIsClock, portPinFourIsData}, 2'b11);
			check(serialClkDiv, div);
		end
		wr(`ADDR_TIMER_SERIAL_CTRL, 8'h00);
		rdChk(`ADDR_TIMER_SERIAL_CTRL, 8'h00);
		check({timerRun, portPinFiveIsClock, portPinFourIsData}, 3'b000);
		$display("timer and serial control done");
	endtask
	task automatic t_modcmp();
		watchdogUnderflow <= 1'b1;
		comparatorPin <= 1'b1;
		wr(`ADDR_MOD_CMP_CTRL, 8'hff);
		rdChk(`ADDR_MOD_CMP_CTRL, 8'hfe);
		check({modulatorMode, comparatorEnable}, 4'hf);
		check(comparatorPinOut, 1'b1);
		watchdogUnderflow <= 1'b0;
		comparatorPin <= 1'b0;
		wr(`ADDR_MOD_CMP_CTRL, 8'h00);
		rdChk(`ADDR_MOD_CMP_CTRL, 8'h00);
		check(comparatorPinOut, 1'b0);
		$display("modulator and comparator control done");
	endtask
	task automatic t_flags();
		serialBusy <= 1'b1;
		alu(1'b1, 1'b0);
		rdChk(`ADDR_STATUS_WORD, 8'h44);
		alu(1'b0, 1'b1);
		rdChk(`ADDR_STATUS_WORD, 8'h84);
		serialBusy <= 1'b0;
		alu(1'b0, 1'b0);
		rdChk(`ADDR_STATUS_WORD, 8'h00);
		$display("carry and busy flags done");
	endtask
	task automatic t_pending();
		far.timerEvent(1'b0);
		rdChk(`ADDR_STATUS_WORD, 8'h20);
		wr(`ADDR_STATUS_WORD, 8'h00);
		rdChk(`ADDR_STATUS_WORD, 8'h00);
		far.timerEvent(1'b1);
		rdChk(`ADDR_STATUS_WORD, 8'h20);
		wr(`ADDR_STATUS_WORD, 8'h00);
		far.pinLevel(1'b1);
		rdChk(`ADDR_STATUS_WORD, 8'h08);
		wr(`ADDR_STATUS_WORD, 8'h00);
		far.pinLevel(1'b0);
		rdChk(`ADDR_STATUS_WORD, 8'h00);
		wr(`ADDR_TIMER_SERIAL_CTRL, 8'h04);
		far.pinLevel(1'b1);
		rdChk(`ADDR_STATUS_WORD, 8'h00);
		far.pinLevel(1'b0);
		rdChk(`ADDR_STATUS_WORD, 8'h08);
		wr(`ADDR_STATUS_WORD, 8'h00);
		wr(`ADDR_TIMER_SERIAL_CTRL, 8'h00);
		$display("pending flags done");
	endtask
	task automatic t_ack();
		fetch(1'b1, 8'h5a);
		wr(`ADDR_STATUS_WORD, 8'h11);
		bnd('0, 15'h1234);
		check(busyCnt, 0);
		far.timerEvent(1'b0);
		bnd('0, 15'h1234);
		check(busyCnt, 6);
		check({loadAt[3:0], loadVal}, {4'h3, `IRQ_VECTOR});
		check(req1, {8'h6f, 8'h34, 2'b10});
		check(req2, {8'h6e, 8'h12, 2'b10});
		rdChk(`ADDR_STACK_PTR, 8'h6d);
		rdChk(`ADDR_STATUS_WORD, 8'h30);
		// re-arming inside the handler lets the still-pending source nest
		wr(`ADDR_STATUS_WORD, 8'h31);
		bnd('0, 15'h0155);
		check(req1, {8'h6d, 8'h55, 2'b10});
		check(loadVal, `IRQ_VECTOR);
		wr(`ADDR_STATUS_WORD, 8'h10);
		bnd(3'b001, 15'h0000);
		check(busyCnt, 3);
		check({loadAt[3:0], loadVal}, {4'h3, 15'h0155});
		rdChk(`ADDR_STATUS_WORD, 8'h11);
		rdChk(`ADDR_STACK_PTR, 8'h6d);
		wr(`ADDR_STATUS_WORD, 8'h10);
		bnd(3'b100, 15'h0000);
		check({skipSeen, loadVal}, {1'b0, 15'h1234});
		rdChk(`ADDR_STATUS_WORD, 8'h10);
		rdChk(`ADDR_STACK_PTR, 8'h6f);
		$display("acknowledge, nesting and returns done");
	endtask
	task automatic t_soft();
		fetch(1'b0, 8'h77);
		@(posedge clk_sys);
		check(fetchData, `UNMAPPED_FETCH);
		wr(`ADDR_STATUS_WORD, 8'h01);
		bnd('0, 15'h0400);
		check({busyCnt[3:0], loadVal}, {4'h6, `IRQ_VECTOR});
		rdChk(`ADDR_STATUS_WORD, 8'h01);
		// handler leaves by return-and-skip past the zero opcode
		fetch(1'b1, 8'h5a);
		bnd(3'b010, 15'h0000);
		check({skipSeen, loadVal}, {1'b1, 15'h0400});
		$display("software trap done");
	endtask
	task automatic t_unbalanced();
		wr(`ADDR_STATUS_WORD, 8'h00);
		bnd(3'b100, 15'h0000);
		check(loadVal, 15'h7fff);
		rdChk(`ADDR_STACK_PTR, 8'h71);
		fetch(1'b0, 8'h3b);
		bnd('0, 15'h7fff);
		check(loadVal, `IRQ_VECTOR);
		$display("unbalanced return done");
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		results();
	end
	initial begin
		n_fail = 0;
		tests_run = 0;
		resetn = 1'b0;
		memReq = '0;
		otherRdData = 8'h00;
		otherRdHit = 1'b0;
		fetchEn = 1'b0;
		romRdData = 8'h00;
		romRdHit = 1'b0;
		instrBoundary = 1'b0;
		retKind = '0;
		pcNow = 15'h0000;
		aluFlagWe = 1'b0;
		aluCarry = 1'b0;
		aluHalfCarry = 1'b0;
		serialBusy = 1'b0;
		watchdogUnderflow = 1'b0;
		comparatorPin = 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_timer_ctrl();
		t_modcmp();
		t_flags();
		t_pending();
		t_ack();
		t_soft();
		t_unbalanced();
		results();
	end
endmodule // interrupt_and_control_regs_bench

// ===== verification/irq_far_side.sv
// Purpose: far-side model, interrupt sources and the stack RAM
// Assumes: stack RAM at 00..6f, combinational read, write on edge
// Notes: absent RAM drives a changing pattern, never a steady ff
`timescale 1ns/100ps
module irq_far_side (
	// clock
	input  wire logic                   clk_sys,
	// stack port
	input  wire irq_ctrl_pkg::mem_req_t stackReq,
	output logic [7:0]                  stackRdData,
	output logic                        stackRdHit,
	// sources
	output logic                        extIrqPin,
	output logic                        timerUnderflow,
	output logic                        timerCapture
);
	import irq_ctrl_pkg::*;
	logic [7:0] ram [0:127];
	logic [7:0] junk;
	initial begin
		extIrqPin = 1'b0;
		timerUnderflow = 1'b0;
		timerCapture = 1'b0;
		junk = 8'h00;
	end
	always_ff @(posedge clk_sys) begin
		junk <= junk + 8'h35;
		if (stackReq.wrEn && stackReq.addr < 8'h70) begin
			ram[stackReq.addr[6:0]] <= stackReq.wrData;
		end
	end
	// design must supply ff itself for absent cells
	assign stackRdHit = stackReq.addr < 8'h70;
	assign stackRdData = stackRdHit ? ram[stackReq.addr[6:0]] : junk;
	// one-cycle event, underflow or capture
	task automatic timerEvent(input logic capture);
		@(posedge clk_sys);
		timerUnderflow <= !capture;
		timerCapture <= capture;
		@(posedge clk_sys);
		timerUnderflow <= 1'b0;
		timerCapture <= 1'b0;
	endtask
	// pin change, then time for sync and edge detect
	task automatic pinLevel(input logic v);
		@(posedge clk_sys);
		extIrqPin <= v;
		repeat (5) @(posedge clk_sys);
	endtask
endmodule // irq_far_side
